/* verilog/xmc_defs.vh */
/*
 * Constants for the external memory bus controller: register offsets,
 * field positions, reset values, address boundaries and sector limits.
 * Assumes it is included by bare name from the design file.
 */
`ifndef XMC_DEFS_VH
`define XMC_DEFS_VH

// Register offsets on the plain register port
`define XMC_ADDR_W         2
`define XMC_OFF_CONFIG     2'h0
`define XMC_OFF_KEEPER     2'h1

// Config register fields
`define XMC_CFG_EN_BIT     7
`define XMC_CFG_SRL_HI     6
`define XMC_CFG_SRL_LO     4
`define XMC_CFG_UPW_HI     3
`define XMC_CFG_UPW_LO     2
`define XMC_CFG_LOW_HI     1
`define XMC_CFG_LOW_LO     0
`define XMC_CFG_RESET      8'h00

// Keeper and mask register fields
`define XMC_KM_KEEP_BIT    7
`define XMC_KM_MASK_HI     2
`define XMC_KM_MASK_LO     0
`define XMC_KM_WMASK       8'h87
`define XMC_KM_RESET       8'h00

// Address map
`define XMC_INT_TOP        16'h20FF
`define XMC_SECT_BASE      16'h2100

// Upper sector start per limit code 010..111
`define XMC_LIM_2          16'h4000
`define XMC_LIM_3          16'h6000
`define XMC_LIM_4          16'h8000
`define XMC_LIM_5          16'hA000
`define XMC_LIM_6          16'hC000
`define XMC_LIM_7          16'hE000

// Wait-state codes
`define XMC_WS_NONE        2'h0
`define XMC_WS_ONE         2'h1
`define XMC_WS_TWO         2'h2
`define XMC_WS_TWO_HOLD    2'h3

`endif

/* verilog/xmc_ctrl.v */
/*
 * External memory bus controller: two control registers, address map
 * decode, sector and wait-state selection, strobe sequencing, bus keeper,
 * high address masking and pin takeover of the port pins.
 * Assumes a core request port synchronous to i_clk, one request at a time,
 * and a pad ring that resolves pins from the active-low output enables.
 */
`timescale 1ns/1ps
`include "xmc_defs.vh"

// Summary of operation
// - Enable bit hands data, address, latch and strobe pins to the memory interface.
// - While enabled, interface pin control overrides the port direction settings.
// - Enable cleared: no external access, pins follow port values and directions.
// - Sector limit field sits in bits 6..4, resets zero, meaning one sector.
// - With one sector, every access uses the upper sector wait bits.
// - Codes 00x: all upper; 010..111 put upper start at 4000..E000.
// - Bits 3..2 select wait states for the upper sector.
// - Bits 1..0 select wait states for the lower sector.
// - Waits: 0, +1 strobe, +2 strobe, +2 strobe plus one idle cycle.
// - Keeper bit holds last driven data value while the lines float.
// - Keeper follows only its own bit, regardless of interface enable.
// - Bits 6..3 of the keeper register are reserved and read zero.
// - Mask code n removes n top address bits; 7 removes all eight.
// - Addresses up to 20FF are internal and never go external.
// - Internal accesses still toggle address, data and latch, never strobes.
// - Low address valid at latch fall; latch stays low during data phase.
module xmc_ctrl #(
	parameter DATA_W = 8,
	parameter HI_W   = 8
) (
	// Clock and reset
	input  wire              i_clk,
	input  wire              i_rst,
	// Register port
	input  wire [`XMC_ADDR_W-1:0] i_reg_addr,
	input  wire [7:0]        i_reg_wdata,
	input  wire              i_reg_wr,
	input  wire              i_reg_rd,
	output reg  [7:0]        o_reg_rdata,
	// Core data-space request
	input  wire              i_req,
	input  wire              i_req_write,
	input  wire [15:0]       i_req_addr,
	input  wire [DATA_W-1:0] i_req_wdata,
	output reg               o_req_done,
	output reg               o_req_ext,
	output reg  [DATA_W-1:0] o_req_rdata,
	// Port values and directions for normal pin use (direction 1 = output)
	input  wire [DATA_W-1:0] i_port_ad_out,
	input  wire [DATA_W-1:0] i_port_ad_dir,
	input  wire [HI_W-1:0]   i_port_hi_out,
	input  wire [HI_W-1:0]   i_port_hi_dir,
	// Multiplexed address/data pins
	input  wire [DATA_W-1:0] i_ad_pin,
	output reg  [DATA_W-1:0] o_ad_pin,
	output reg  [DATA_W-1:0] o_ad_oe_n,
	output reg               o_ad_keep,
	// High address pins
	output reg  [HI_W-1:0]   o_hi_pin,
	output reg  [HI_W-1:0]   o_hi_oe_n,
	// Strobes and latch (strobes active low)
	output reg               o_ale,
	output reg               o_rd_n,
	output reg               o_wr_n,
	output reg               o_iface_on
);

	/********************************************
	 * Constants
	 ********************************************/
	localparam ST_IDLE  = 3'h0;
	localparam ST_ADDR  = 3'h1;
	localparam ST_STRB  = 3'h2;
	localparam ST_WAIT  = 3'h3;
	localparam ST_DONE  = 3'h4;
	localparam ST_HOLD  = 3'h5;

	/********************************************
	 * Functions
	 ********************************************/
	// Start of the upper sector for a limit code
	function [15:0] upper_start;
		input [2:0] code;
		begin
			case (code)
				3'h2:    upper_start = `XMC_LIM_2;
				3'h3:    upper_start = `XMC_LIM_3;
				3'h4:    upper_start = `XMC_LIM_4;
				3'h5:    upper_start = `XMC_LIM_5;
				3'h6:    upper_start = `XMC_LIM_6;
				3'h7:    upper_start = `XMC_LIM_7;
				default: upper_start = `XMC_SECT_BASE;
			endcase
		end
	endfunction

	// Mask of high address bits still used by the interface
	function [HI_W-1:0] hi_keep_mask;
		input [2:0] code;
		integer k;
		begin
			hi_keep_mask = {HI_W{1'b0}};
			for (k = 0; k < HI_W; k = k + 1) begin
				if (code != 3'h7 && k < HI_W - code)
					hi_keep_mask[k] = 1'b1;
			end
		end
	endfunction

	/********************************************
	 * Registers
	 ********************************************/
	reg  [7:0]        cfg_ff;
	reg  [7:0]        km_ff;
	reg  [2:0]        state_ff;
	reg  [2:0]        nxt_state;
	reg  [1:0]        wcnt_ff;
	reg  [1:0]        nxt_wcnt;
	reg  [1:0]        ws_ff;
	reg               wr_ff;
	reg               ext_ff;
	reg  [15:0]       addr_ff;
	reg  [DATA_W-1:0] wdata_ff;
	reg  [DATA_W-1:0] last_ad_ff;

	wire              en      = cfg_ff[`XMC_CFG_EN_BIT];
	wire [2:0]        srl     = cfg_ff[`XMC_CFG_SRL_HI:`XMC_CFG_SRL_LO];
	wire [1:0]        up_ws   = cfg_ff[`XMC_CFG_UPW_HI:`XMC_CFG_UPW_LO];
	wire [1:0]        lo_ws   = cfg_ff[`XMC_CFG_LOW_HI:`XMC_CFG_LOW_LO];
	wire              keep_en = km_ff[`XMC_KM_KEEP_BIT];
	wire [2:0]        hmask   = km_ff[`XMC_KM_MASK_HI:`XMC_KM_MASK_LO];
	wire [HI_W-1:0]   hi_used = hi_keep_mask(hmask);

	// Internal space never leaves the chip, and nothing does when disabled
	wire req_ext   = en && (i_req_addr > `XMC_INT_TOP);
	// One sector for codes 00x: upper wait bits cover everything
	wire one_sect  = (srl[2:1] == 2'h0);
	wire in_upper  = one_sect || (i_req_addr >= upper_start(srl));
	wire [1:0] sel_ws = in_upper ? up_ws : lo_ws;

	/********************************************
	 * Register port
	 ********************************************/
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cfg_ff      <= `XMC_CFG_RESET;
			km_ff       <= `XMC_KM_RESET;
			o_reg_rdata <= 8'h00;
		end else begin
			if (i_reg_wr && i_reg_addr == `XMC_OFF_CONFIG)
				cfg_ff <= i_reg_wdata;
			if (i_reg_wr && i_reg_addr == `XMC_OFF_KEEPER)
				km_ff <= i_reg_wdata & `XMC_KM_WMASK;
			if (i_reg_rd) begin
				case (i_reg_addr)
					`XMC_OFF_CONFIG: o_reg_rdata <= cfg_ff;
					`XMC_OFF_KEEPER: o_reg_rdata <= km_ff;
					default:         o_reg_rdata <= 8'h00;
				endcase
			end else begin
				o_reg_rdata <= 8'h00;
			end
		end
	end

	/********************************************
	 * Access sequencer
	 ********************************************/
	// Every request while enabled runs the same address phase so internal accesses
	// show latch activity too; only external ones assert strobes.
	always @* begin
		nxt_state = state_ff;
		nxt_wcnt  = wcnt_ff;
		case (state_ff)
			ST_IDLE: begin
				if (i_req)
					nxt_state = en ? ST_ADDR : ST_DONE;
			end
			ST_ADDR: begin
				nxt_state = ST_STRB;
				nxt_wcnt  = (ws_ff == `XMC_WS_NONE) ? 2'h0 :
				            (ws_ff == `XMC_WS_ONE)  ? 2'h1 : 2'h2;
			end
			ST_STRB: begin
				if (wcnt_ff == 2'h0)
					nxt_state = ST_DONE;
				else
					nxt_state = ST_WAIT;
			end
			ST_WAIT: begin
				nxt_wcnt = wcnt_ff - 2'h1;
				if (wcnt_ff == 2'h1)
					nxt_state = ST_DONE;
			end
			ST_DONE: begin
				nxt_state = (ext_ff && ws_ff == `XMC_WS_TWO_HOLD) ? ST_HOLD : ST_IDLE;
			end
			ST_HOLD: begin
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_ff    <= ST_IDLE;
			wcnt_ff     <= 2'h0;
			ws_ff       <= `XMC_WS_NONE;
			wr_ff       <= 1'b0;
			ext_ff      <= 1'b0;
			addr_ff     <= 16'h0000;
			wdata_ff    <= {DATA_W{1'b0}};
			o_req_done  <= 1'b0;
			o_req_ext   <= 1'b0;
			o_req_rdata <= {DATA_W{1'b0}};
		end else begin
			state_ff   <= nxt_state;
			wcnt_ff    <= nxt_wcnt;
			o_req_done <= (state_ff == ST_DONE);
			if (state_ff == ST_IDLE && i_req) begin
				ws_ff    <= sel_ws;
				wr_ff    <= i_req_write;
				ext_ff   <= req_ext;
				addr_ff  <= i_req_addr;
				wdata_ff <= i_req_wdata;
			end
			if (state_ff == ST_DONE) begin
				o_req_ext   <= ext_ff;
				o_req_rdata <= i_ad_pin;
			end
		end
	end

	/********************************************
	 * Pins
	 ********************************************/
	wire in_cycle  = (state_ff != ST_IDLE) && (state_ff != ST_HOLD) && en;
	wire addr_ph   = (state_ff == ST_ADDR);
	wire data_ph   = in_cycle && !addr_ph;
	wire drive_wr  = data_ph && wr_ff;
	wire strobe    = ext_ff && (state_ff == ST_STRB || state_ff == ST_WAIT);

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_ad_pin   <= {DATA_W{1'b0}};
			o_ad_oe_n  <= {DATA_W{1'b1}};
			o_ad_keep  <= 1'b0;
			o_hi_pin   <= {HI_W{1'b0}};
			o_hi_oe_n  <= {HI_W{1'b1}};
			o_ale      <= 1'b0;
			o_rd_n     <= 1'b1;
			o_wr_n     <= 1'b1;
			o_iface_on <= 1'b0;
			last_ad_ff <= {DATA_W{1'b0}};
		end else begin
			o_iface_on <= en;
			o_ad_keep  <= keep_en;
			// Latch high in address phase, low for data; falls with address valid
			o_ale  <= (nxt_state == ST_ADDR);
			o_rd_n <= !(strobe && !wr_ff);
			o_wr_n <= !(strobe && wr_ff);
			if (en) begin
				// Interface owns the pins whatever the port directions say
				if (nxt_state == ST_ADDR) begin
					o_ad_pin  <= i_req_addr[DATA_W-1:0];
					o_ad_oe_n <= {DATA_W{1'b0}};
				end else if (addr_ph || drive_wr) begin
					o_ad_pin  <= addr_ph ? addr_ff[DATA_W-1:0] : wdata_ff;
					o_ad_oe_n <= {DATA_W{1'b0}};
					if (drive_wr)
						o_ad_pin <= wdata_ff;
				end else begin
					o_ad_pin  <= keep_en ? last_ad_ff : {DATA_W{1'b0}};
					o_ad_oe_n <= {DATA_W{1'b1}};
				end
			end else begin
				o_ad_pin  <= i_port_ad_out;
				o_ad_oe_n <= ~i_port_ad_dir;
			end
			if (!o_ad_oe_n[0])
				last_ad_ff <= o_ad_pin;
			begin : hi_pins
				integer b;
				for (b = 0; b < HI_W; b = b + 1) begin
					// Masked bits fall back to port use, so software can alias low memory
					if (en && hi_used[b]) begin
						o_hi_pin[b]  <= (nxt_state == ST_ADDR) ? i_req_addr[DATA_W+b]
						                : o_hi_pin[b];
						o_hi_oe_n[b] <= 1'b0;
					end else begin
						o_hi_pin[b]  <= i_port_hi_out[b];
						o_hi_oe_n[b] <= ~i_port_hi_dir[b];
					end
				end
			end
		end
	end

endmodule // xmc_ctrl

/* verif/xmc_ctrl_asserts.sv */
/* Port checker for the external memory bus controller.
   Assumes one clock and a bind onto every xmc_ctrl instance. */
`timescale 1ns/1ps
module xmc_ctrl_asserts #(
	parameter DATA_W = 8,
	parameter HI_W   = 8
) (
	// Clock, reset, register port
	input wire logic              i_clk,
	input wire logic              i_rst,
	input wire logic [1:0]        i_reg_addr,
	input wire logic [7:0]        i_reg_wdata,
	input wire logic              i_reg_wr,
	input wire logic              i_reg_rd,
	input wire logic [7:0]        o_reg_rdata,
	// Requests and pins
	input wire logic              i_req,
	input wire logic [15:0]       i_req_addr,
	input wire logic [DATA_W-1:0] i_port_ad_dir,
	input wire logic [DATA_W-1:0] o_ad_oe_n,
	input wire logic              o_ad_keep,
	input wire logic              o_ale,
	input wire logic              o_rd_n,
	input wire logic              o_wr_n,
	input wire logic              o_iface_on
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_cfg_wr; i_reg_wr && i_reg_addr == 2'h0; endsequence
	sequence s_km_wr; i_reg_wr && i_reg_addr == 2'h1; endsequence
	sequence s_int_req; i_req && i_req_addr <= 16'h20FF; endsequence
	sequence s_off2; !o_iface_on && !$past(o_iface_on); endsequence
	sequence s_strb_idle; o_rd_n && o_wr_n; endsequence
	// Register then output flop: the pin shows the new bit two edges after the write
	property p_en; s_cfg_wr |=> ##1 o_iface_on == $past(i_reg_wdata[7], 2); endproperty
	a_en: assert property (p_en) else $error("enable flag wrong");
	property p_keep; s_km_wr |=> ##1 o_ad_keep == $past(i_reg_wdata[7], 2); endproperty
	a_keep: assert property (p_keep) else $error("keeper flag wrong");
	property p_rsvd; i_reg_rd && i_reg_addr == 2'h1 |=> o_reg_rdata[6:3] == 4'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
	property p_int; s_int_req |-> s_strb_idle [*6]; endproperty
	a_int: assert property (p_int) else $error("strobe on internal access");
	property p_off; s_off2 |-> s_strb_idle; endproperty
	a_off: assert property (p_off) else $error("strobe while disabled");
	property p_dir; s_off2 ##0 !$past(o_iface_on, 2) |-> o_ad_oe_n == ~$past(i_port_ad_dir);
	endproperty
	a_dir: assert property (p_dir) else $error("port direction ignored");
	property p_ale; o_ale |-> s_strb_idle; endproperty
	a_ale: assert property (p_ale) else $error("latch high in data phase");
	property p_strb; $fell(o_rd_n) |-> ##[1:3] o_rd_n; endproperty
	a_strb: assert property (p_strb) else $error("read strobe too long");
endmodule // xmc_ctrl_asserts

bind xmc_ctrl xmc_ctrl_asserts #(.DATA_W(DATA_W), .HI_W(HI_W)) i_xmc_ctrl_asserts (.i_clk,
	.i_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_req,
	.i_req_addr, .i_port_ad_dir, .o_ad_oe_n, .o_ad_keep, .o_ale, .o_rd_n, .o_wr_n, .o_iface_on);

/* verif/xmc_sram_model.sv */
/* Byte memory behind an address latch on the multiplexed bus.
   Assumes active-low strobes and a latch open while ALE is high. */
`timescale 1ns/1ps
module xmc_sram_model (
	// Bus side
	input  wire logic       i_clk,
	input  wire logic       i_ale,
	input  wire logic       i_rd_n,
	input  wire logic       i_wr_n,
	input  wire logic [7:0] i_ad,
	output wire logic [7:0] o_ad,
	output wire logic       o_drv
);
	logic [7:0] mem_ff [256];
	logic [7:0] lat_ff;
	always @(posedge i_clk) begin
		if (i_ale)
			lat_ff <= i_ad;
		if (!i_wr_n)
			mem_ff[lat_ff] <= i_ad;
	end
	// Drives only under the read strobe, so the pad sees release otherwise
	assign o_ad = mem_ff[lat_ff];
	assign o_drv = !i_rd_n;
endmodule // xmc_sram_model

/* verif/tb.sv */
/* Bench for the external memory bus controller.
   Assumes the memory model and the bound checker are compiled first. */
`timescale 1ns/1ps
module tb;
	logic        i_clk, i_rst, i_reg_wr, i_reg_rd, i_req, i_req_write, m_drv;
	logic [1:0]  i_reg_addr;
	logic [7:0]  i_reg_wdata, o_reg_rdata, i_req_wdata, o_req_rdata, m_ad, last_ff;
	logic [7:0]  i_port_ad_out, i_port_ad_dir, i_port_hi_out, i_port_hi_dir;
	logic [7:0]  ad_w, o_ad_pin, o_ad_oe_n, o_hi_pin, o_hi_oe_n;
	logic [15:0] i_req_addr;
	logic        o_req_done, o_req_ext, o_ad_keep, o_ale, o_rd_n, o_wr_n, o_iface_on;
	int          fail_count, checks, cyc, lat, base;
	// Floating pad: keeper holds, else a level that changes every cycle
	assign ad_w = (o_ad_pin & ~o_ad_oe_n)
		| (o_ad_oe_n & (m_drv ? m_ad : o_ad_keep ? last_ff : ~last_ff));
	xmc_ctrl i_xmc_ctrl (.i_clk, .i_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
		.o_reg_rdata, .i_req, .i_req_write, .i_req_addr, .i_req_wdata, .o_req_done,
		.o_req_ext, .o_req_rdata, .i_port_ad_out, .i_port_ad_dir, .i_port_hi_out,
		.i_port_hi_dir, .i_ad_pin(ad_w), .o_ad_pin, .o_ad_oe_n, .o_ad_keep, .o_hi_pin,
		.o_hi_oe_n, .o_ale, .o_rd_n, .o_wr_n, .o_iface_on);
	xmc_sram_model i_xmc_sram_model (.i_clk, .i_ale(o_ale), .i_rd_n(o_rd_n),
		.i_wr_n(o_wr_n), .i_ad(ad_w), .o_ad(m_ad), .o_drv(m_drv));
	initial begin
		i_clk = 0;
		forever #12.5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		last_ff <= ad_w;
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			fail_count++;
			results;
		end
	end
	task automatic chk(string n, logic [15:0] s, logic [15:0] e);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(logic [1:0] a, logic [7:0] d);
		@(posedge i_clk);
		i_reg_wr <= 1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clk);
		i_reg_wr <= 0;
	endtask
	task automatic rchk(logic [1:0] a, logic [7:0] e, string n);
		@(posedge i_clk);
		i_reg_rd <= 1;
		i_reg_addr <= a;
		@(posedge i_clk);
		i_reg_rd <= 0;
		@(negedge i_clk);
		chk(n, o_reg_rdata, e);
	endtask
	// Latency counted in cycles from the taking edge to the done pulse
	task automatic acc(logic w, logic [15:0] a, logic [7:0] d);
		@(posedge i_clk);
		i_req <= 1;
		i_req_write <= w;
		i_req_addr <= a;
		i_req_wdata <= d;
		@(posedge i_clk);
		i_req <= 0;
		lat = 0;
		do begin
			@(negedge i_clk);
			lat++;
		end while (o_req_done !== 1'b1 && lat < 20);
		repeat (2) @(posedge i_clk);
		@(negedge i_clk);
	endtask
	task automatic t_regs;
		rchk(2'h0, 8'h00, "cfg_reset");
		rchk(2'h1, 8'h00, "km_reset");
		wr(2'h1, 8'hFF);
		rchk(2'h1, 8'h87, "km_reserved");
		chk("keep_when_off", o_ad_keep, 1);
		wr(2'h2, 8'hFF);
		rchk(2'h2, 8'h00, "unmapped");
		wr(2'h0, 8'h5A);
		rchk(2'h0, 8'h5A, "cfg_rw");
		wr(2'h0, 8'h00);
		$display("regs test done");
	endtask
	task automatic t_off;
		@(posedge i_clk);
		i_port_ad_out <= 8'h3C;
		i_port_ad_dir <= 8'hF0;
		acc(0, 16'h4000, 8'h00);
		base = lat;
		chk("off_ext", o_req_ext, 0);
		chk("off_oe", o_ad_oe_n, 8'h0F);
		chk("off_pin", o_ad_pin & 8'hF0, 8'h30);
		$display("disabled test done");
	endtask
	task automatic t_wait;
		logic [1:0] n [4] = '{0, 1, 2, 2};
		for (int k = 0; k < 4; k++) begin
			wr(2'h0, 8'h80 | 8'(k << 2) | 8'(3 - k));
			acc(0, 16'hFFFF, 8'h00);
			chk("wait_one_sector", lat, base + 2 + n[k]);
		end
		for (int c = 1; c < 8; c++) begin
			wr(2'h0, 8'h82 | 8'(c << 4));
			acc(0, (c < 2) ? 16'h2100 : 16'(c * 'h2000 - 1), 8'h00);
			chk("sector_low", lat, (c < 2) ? base + 2 : base + 4);
			acc(0, 16'(c * 'h2000 + 'h100), 8'h00);
			chk("sector_up", lat, base + 2);
		end
		$display("wait test done");
	endtask
	task automatic t_data;
		wr(2'h0, 8'h80);
		wr(2'h1, 8'h80);
		acc(1, 16'h2155, 8'hA5);
		acc(0, 16'h2155, 8'h00);
		chk("ext_read", o_req_rdata, 8'hA5);
		chk("ext_flag", o_req_ext, 1);
		chk("keep_on", o_ad_keep, 1);
		acc(0, 16'h20FF, 8'h00);
		chk("int_flag", o_req_ext, 0);
		$display("data test done");
	endtask
	task automatic t_mask;
		logic [7:0] e;
		for (int m = 0; m < 8; m++) begin
			wr(2'h1, 8'(m));
			repeat (2) @(negedge i_clk);
			// Code 7 releases all eight pins, not seven
			e = 8'hFF << (8 - m);
			if (m == 7)
				e = 8'hFF;
			chk("mask_released", o_hi_oe_n, e);
		end
		wr(2'h1, 8'h02);
		i_port_hi_dir <= 8'hFF;
		repeat (3) @(negedge i_clk);
		// Top two bits come from the port, so C1xx aliases to 01xx
		acc(1, 16'hC101, 8'hAA);
		chk("mask_port_low", {o_hi_oe_n[7:6], o_hi_pin}, 16'h0001);
		$display("mask test done");
	endtask
	task automatic results;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		{i_reg_wr, i_reg_rd, i_req, i_req_write, i_reg_addr, i_reg_wdata} = '0;
		{i_req_addr, i_req_wdata, i_port_ad_out, i_port_ad_dir} = '0;
		{i_port_hi_out, i_port_hi_dir} = '0;
		i_rst = 1;
		repeat (3) @(posedge i_clk);
		i_rst <= 0;
		t_regs;
		t_off;
		t_wait;
		t_data;
		t_mask;
		results;
	end
endmodule // tb
